/* File: core/spm_map.vh */
// Constants for the serial persistent memory port: opcodes, lane modes, timing
`ifndef SPM_MAP_VH
`define SPM_MAP_VH

// Clock rate of the block in MHz
`define SPM_CLK_MHZ         100

// Times in microseconds
`define SPM_PU_WAIT_US      250
`define SPM_DEEP_ENTRY_US   3
`define SPM_DEEP_EXIT_US    400
`define SPM_HIB_ENTRY_US    3
`define SPM_HIB_EXIT_US     450

// Instruction register
`define SPM_IR_WIDTH        8
`define SPM_OP_READ         8'h03
`define SPM_OP_WRITE        8'h02
`define SPM_OP_READ_AUG     8'h4b
`define SPM_OP_WRITE_AUG    8'h42
`define SPM_OP_DEEP_SLEEP   8'hb9
`define SPM_OP_HIBERNATE    8'hba

// Lane modes, command-address-data
`define SPM_MODE_111        3'h0
`define SPM_MODE_112        3'h1
`define SPM_MODE_122        3'h2
`define SPM_MODE_222        3'h3
`define SPM_MODE_114        3'h4
`define SPM_MODE_144        3'h5
`define SPM_MODE_444        3'h6

// Mode byte upper nibbles
`define SPM_XIP_ON_NIB      4'ha
`define SPM_XIP_OFF_NIB     4'hf

// Address maps
`define SPM_ADDR_BYTES      2'h3
`define SPM_MAIN_HI_LSB     21
`define SPM_AUG_HI_LSB      8
`define SPM_AUG_SECT_LSB    5
`define SPM_PROT_BASE_SHIFT 14

`endif

/* File: core/spm_sync.v */
// Two-flop synchroniser for the serial pins
`timescale 1ns/100ps
module spm_sync
(
  // Clock and reset
  input  wire       clock,
  input  wire       rst,
  // Asynchronous pins and their synchronised copies
  input  wire [6:0] pin_in,
  output wire [6:0] pin_sync
);

  reg [6:0] meta_r;
  reg [6:0] sync_r;

  genvar i;
  generate
    for (i = 0; i < 7; i = i + 1)
    begin : g_bit
      // Idle high so chip select starts deselected
      always @(posedge clock or posedge rst)
      begin
        if (rst)
        begin
          meta_r[i] <= 1'b1;
          sync_r[i] <= 1'b1;
        end
        else
        begin
          meta_r[i] <= pin_in[i];
          sync_r[i] <= meta_r[i];
        end
      end
    end
  endgenerate

  assign pin_sync = sync_r;

endmodule

/* File: core/spm_port.v */
// Serial front end of a persistent memory: lanes, instruction decode, power states
//
// How it works
// - Chip select low selects the device; only then is the serial bus obeyed.
// - After deselect, stay active until the array reports no operation busy.
// - Each transaction outside command-free access starts with an opcode shifted into an 8-bit instruction register.
// - Single-lane mode uses the input lane; dual uses lanes 0-1, quad 0-3.
// - Command, address and data phases each use the lane count of the mode.
// - Seven lane modes; 1-1-1 reads out on lane 1, others share lanes.
// - Command, address and input data are sampled on rising serial clock edges.
// - Read data is launched on falling edges, starting on a falling edge.
// - Mode byte after the address: upper nibble A enables, F disables command-free access.
// - With command-free access on, transactions start at the address with the last command.
// - Register writes are blocked by the pin scheme or the status-bit scheme; array writes ignore the pin.
// - A separate 256-byte augmented array is addressed apart from the main array.
// - Deep sleep and hibernate keep array contents and all configuration.
// - After power-up completes the device is in standby with nothing pending.
// - Deep sleep reached within 3 us; exit takes up to 400 us.
// - Hibernate reached within 3 us; exit takes up to 450 us.
// - Main addresses are 24 bits; bits 23-21 zero, 20-0 select the byte.
// - Augmented addresses have bits 23-8 zero; bits 7-5 select a 32-byte section.
// - Each augmented section can be write protected; writes into it are rejected.
// - Deselected device ignores inputs and floats outputs; a select edge is needed after power-up.
// - Clock modes 0 and 3 only, single data rate.
`timescale 1ns/100ps
`include "spm_map.vh"
module spm_port
#(
  parameter [15:0] PU_WAIT_CYC  = `SPM_PU_WAIT_US * `SPM_CLK_MHZ,
  parameter [15:0] DEEP_EXIT_CYC = `SPM_DEEP_EXIT_US * `SPM_CLK_MHZ,
  parameter [15:0] HIB_EXIT_CYC  = `SPM_HIB_EXIT_US * `SPM_CLK_MHZ
)
(
  // Clock and reset
  input  wire        clock,
  input  wire        rst,
  // Serial pins
  input  wire        spi_cs_n,
  input  wire        spi_sck,
  input  wire [3:0]  spi_io_in,
  output wire [3:0]  spi_io_out,
  output wire [3:0]  spi_io_oe_n,
  input  wire        spi_wp_n,
  // Configuration from the register block
  input  wire [2:0]  lane_mode,
  input  wire        wr_enable,
  input  wire        wp_pin_en,
  input  wire        prot_bottom,
  input  wire [2:0]  prot_blocks,
  input  wire        aug_lock,
  input  wire [7:0]  aug_sect_prot,
  // Array access
  output wire        mem_rd,
  output wire        mem_wr,
  output wire        mem_aug,
  output wire [23:0] mem_addr,
  output wire [7:0]  mem_wdata,
  input  wire [7:0]  mem_rdata,
  input  wire        mem_busy,
  // Status
  output wire [2:0]  pwr_state,
  output wire        dev_active,
  output wire        reg_wr_allowed,
  output wire        xip_on,
  output wire        wr_rejected
);

  localparam [15:0] DEEP_ENTRY_CYC = `SPM_DEEP_ENTRY_US * `SPM_CLK_MHZ;
  localparam [15:0] HIB_ENTRY_CYC  = `SPM_HIB_ENTRY_US * `SPM_CLK_MHZ;

  // Power states
  localparam [2:0] P_PWRUP   = 3'h0;
  localparam [2:0] P_STANDBY = 3'h1;
  localparam [2:0] P_ACTIVE  = 3'h2;
  localparam [2:0] P_ENT_DPD = 3'h3;
  localparam [2:0] P_DEEP    = 3'h4;
  localparam [2:0] P_ENT_HIB = 3'h5;
  localparam [2:0] P_HIB     = 3'h6;
  localparam [2:0] P_EXIT    = 3'h7;

  // Transaction states
  localparam [2:0] T_IDLE  = 3'h0;
  localparam [2:0] T_CMD   = 3'h1;
  localparam [2:0] T_ADDR  = 3'h2;
  localparam [2:0] T_MODE  = 3'h3;
  localparam [2:0] T_WDATA = 3'h4;
  localparam [2:0] T_RDATA = 3'h5;
  localparam [2:0] T_DONE  = 3'h6;

  localparam [1:0] PH_CMD  = 2'h0;
  localparam [1:0] PH_ADDR = 2'h1;
  localparam [1:0] PH_DATA = 2'h2;

  // Lane count of a phase under a lane mode
  function [2:0] lanes;
    input [2:0] mode;
    input [1:0] ph;
    begin
      case (mode)
        `SPM_MODE_112: lanes = (ph == PH_DATA) ? 3'h2 : 3'h1;
        `SPM_MODE_122: lanes = (ph == PH_CMD) ? 3'h1 : 3'h2;
        `SPM_MODE_222: lanes = 3'h2;
        `SPM_MODE_114: lanes = (ph == PH_DATA) ? 3'h4 : 3'h1;
        `SPM_MODE_144: lanes = (ph == PH_CMD) ? 3'h1 : 3'h4;
        `SPM_MODE_444: lanes = 3'h4;
        default:       lanes = 3'h1;
      endcase
    end
  endfunction

  // Shift lane bits into a byte, most significant first
  function [7:0] shift_in;
    input [7:0] sh;
    input [2:0] w;
    input [3:0] io;
    begin
      if (w == 3'h4)
        shift_in = {sh[3:0], io[3:0]};
      else if (w == 3'h2)
        shift_in = {sh[5:0], io[1:0]};
      else
        shift_in = {sh[6:0], io[0]};
    end
  endfunction

  // Block protection of the main array
  function main_prot;
    input [20:0] a;
    input        bottom;
    input [2:0]  bp;
    reg   [21:0] size;
    begin
      size = 22'h1 << (`SPM_PROT_BASE_SHIFT + bp);
      if (bp == 3'h0)
        main_prot = 1'b0;
      else if (bp == 3'h7)
        main_prot = 1'b1;
      else if (bottom)
        main_prot = ({1'b0, a} < size);
      else
        main_prot = ({1'b0, a} >= (22'h200000 - size));
    end
  endfunction

  // Address of the next byte, wrapping inside its array
  function [23:0] next_addr;
    input [23:0] a;
    input        aug;
    begin
      if (aug)
        next_addr = {a[23:8], a[7:0] + 8'h01};
      else
        next_addr = {a[23:21], a[20:0] + 21'h000001};
    end
  endfunction

  wire [6:0] pins_s;
  wire       cs_s;
  wire       sck_s;
  wire [3:0] io_s;
  wire       wp_s;

  spm_sync u_sync
  (
    .clock    (clock),
    .rst      (rst),
    .pin_in   ({spi_wp_n, spi_io_in, spi_sck, spi_cs_n}),
    .pin_sync (pins_s)
  );

  assign cs_s  = pins_s[0];
  assign sck_s = pins_s[1];
  assign io_s  = pins_s[5:2];
  assign wp_s  = pins_s[6];

  reg        cs_d_r;
  reg        sck_d_r;
  reg        armed_r;
  reg [2:0]  pwr_r;
  reg [15:0] tmr_r;
  reg [2:0]  ts_r;
  reg [7:0]  sh_r;
  reg [3:0]  bits_r;
  reg [1:0]  bytes_r;
  reg [7:0]  ir_r;
  reg [7:0]  xip_cmd_r;
  reg        xip_r;
  reg [23:0] addr_r;
  reg        aug_r;
  reg        vld_r;
  reg        rd_r;
  reg        wr_r;
  reg        rej_r;
  reg [7:0]  wdata_r;
  reg [23:0] maddr_r;
  reg        rd_pend_r;
  reg [7:0]  rbuf_r;
  reg [7:0]  osh_r;
  reg [3:0]  obits_r;
  reg [3:0]  out_r;
  reg [3:0]  oe_n_r;
  reg        sleep_deep_r;
  reg        sleep_hib_r;
  reg        regw_r;

  wire       sck_rise = sck_s & ~sck_d_r;
  wire       sck_fall = ~sck_s & sck_d_r;
  wire       cs_fall  = ~cs_s & cs_d_r;
  wire       cs_rise  = cs_s & ~cs_d_r;
  wire       ready    = (pwr_r == P_STANDBY) || (pwr_r == P_ACTIVE);
  wire       in_xfer  = (ts_r != T_IDLE);
  wire [1:0] phase    = (ts_r == T_CMD) ? PH_CMD : ((ts_r == T_ADDR) || (ts_r == T_MODE)) ? PH_ADDR : PH_DATA;
  wire [2:0] w        = lanes(lane_mode, phase);
  wire [7:0] sh_nxt   = shift_in(sh_r, w, io_s);
  wire [3:0] bits_nxt = bits_r + {1'b0, w};
  wire       byte_end = sck_rise && (bits_nxt == 4'h8);
  wire       is_wr    = (ir_r == `SPM_OP_WRITE) || (ir_r == `SPM_OP_WRITE_AUG);
  wire       is_rd    = (ir_r == `SPM_OP_READ) || (ir_r == `SPM_OP_READ_AUG);
  wire [23:0] a_full  = {addr_r[15:0], sh_nxt};
  wire [7:0]  obyte   = (obits_r == 4'h0) ? rbuf_r : osh_r;
  wire       a_vld    = aug_r ? (addr_r[23:`SPM_AUG_HI_LSB] == 16'h0000)
                              : (addr_r[23:`SPM_MAIN_HI_LSB] == 3'h0);
  wire       wr_block = ~wr_enable
                        | (aug_r ? (aug_lock | aug_sect_prot[addr_r[7:`SPM_AUG_SECT_LSB]])
                                 : main_prot(addr_r[20:0], prot_bottom, prot_blocks));

  // Chip select and serial clock edge detection
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      cs_d_r  <= 1'b1;
      sck_d_r <= 1'b1;
    end
    else
    begin
      cs_d_r  <= cs_s;
      sck_d_r <= sck_s;
    end
  end

  // Power state machine
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      pwr_r   <= P_PWRUP;
      tmr_r   <= PU_WAIT_CYC;
      armed_r <= 1'b0;
    end
    else
    begin
      if (cs_s && ready)
        armed_r <= 1'b1;
      case (pwr_r)
        P_PWRUP:
          if (tmr_r <= 16'h0001)
            pwr_r <= P_STANDBY;
          else
            tmr_r <= tmr_r - 16'h0001;
        P_STANDBY:
          if (~cs_s && armed_r)
            pwr_r <= P_ACTIVE;
        P_ACTIVE:
          if (cs_s && ~mem_busy)
          begin
            if (sleep_deep_r)
            begin
              pwr_r <= P_ENT_DPD;
              tmr_r <= DEEP_ENTRY_CYC;
            end
            else if (sleep_hib_r)
            begin
              pwr_r <= P_ENT_HIB;
              tmr_r <= HIB_ENTRY_CYC;
            end
            else
              pwr_r <= P_STANDBY;
          end
        P_ENT_DPD, P_ENT_HIB:
          if (tmr_r <= 16'h0001)
            pwr_r <= (pwr_r == P_ENT_DPD) ? P_DEEP : P_HIB;
          else
            tmr_r <= tmr_r - 16'h0001;
        P_DEEP, P_HIB:
          if (cs_fall)
          begin
            pwr_r <= P_EXIT;
            tmr_r <= (pwr_r == P_DEEP) ? DEEP_EXIT_CYC : HIB_EXIT_CYC;
          end
        default:
          if (tmr_r <= 16'h0001)
            pwr_r <= P_STANDBY;
          else
            tmr_r <= tmr_r - 16'h0001;
      endcase
    end
  end

  // Transaction engine; config kept in low power
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      ts_r         <= T_IDLE;
      sh_r         <= 8'h00;
      bits_r       <= 4'h0;
      bytes_r      <= 2'h0;
      ir_r         <= 8'h00;
      xip_cmd_r    <= 8'h00;
      xip_r        <= 1'b0;
      addr_r       <= 24'h000000;
      aug_r        <= 1'b0;
      vld_r        <= 1'b0;
      rd_r         <= 1'b0;
      wr_r         <= 1'b0;
      rej_r        <= 1'b0;
      wdata_r      <= 8'h00;
      maddr_r      <= 24'h000000;
      rd_pend_r    <= 1'b0;
      rbuf_r       <= 8'h00;
      osh_r        <= 8'h00;
      obits_r      <= 4'h0;
      out_r        <= 4'h0;
      oe_n_r       <= 4'hf;
      sleep_deep_r <= 1'b0;
      sleep_hib_r  <= 1'b0;
    end
    else
    begin
      rd_r      <= 1'b0;
      wr_r      <= 1'b0;
      rej_r     <= 1'b0;
      rd_pend_r <= rd_r;
      if (rd_pend_r)
        rbuf_r <= vld_r ? mem_rdata : 8'h00;
      if (~ready)
      begin
        sleep_deep_r <= 1'b0;
        sleep_hib_r  <= 1'b0;
      end
      if (cs_rise || cs_s)
      begin
        // Partial bytes drop; nothing committed
        ts_r   <= T_IDLE;
        oe_n_r <= 4'hf;
        if (cs_rise && (ts_r == T_DONE))
        begin
          sleep_deep_r <= (ir_r == `SPM_OP_DEEP_SLEEP);
          sleep_hib_r  <= (ir_r == `SPM_OP_HIBERNATE);
        end
      end
      else if (cs_fall && ready && armed_r)
      begin
        bits_r  <= 4'h0;
        bytes_r <= 2'h0;
        obits_r <= 4'h0;
        if (xip_r)
        begin
          ir_r  <= xip_cmd_r;
          aug_r <= (xip_cmd_r == `SPM_OP_READ_AUG) || (xip_cmd_r == `SPM_OP_WRITE_AUG);
          ts_r  <= T_ADDR;
        end
        else
          ts_r <= T_CMD;
      end
      else if (in_xfer && sck_rise && (ts_r != T_RDATA) && (ts_r != T_DONE))
      begin
        sh_r   <= sh_nxt;
        bits_r <= byte_end ? 4'h0 : bits_nxt;
        if (byte_end)
        begin
          case (ts_r)
            T_CMD:
            begin
              ir_r <= sh_nxt;
              aug_r <= (sh_nxt == `SPM_OP_READ_AUG) || (sh_nxt == `SPM_OP_WRITE_AUG);
              if ((sh_nxt == `SPM_OP_READ) || (sh_nxt == `SPM_OP_WRITE)
                  || (sh_nxt == `SPM_OP_READ_AUG) || (sh_nxt == `SPM_OP_WRITE_AUG))
                ts_r <= T_ADDR;
              else
                ts_r <= T_DONE;
            end
            T_ADDR:
            begin
              addr_r  <= a_full;
              bytes_r <= bytes_r + 2'h1;
              if (bytes_r == `SPM_ADDR_BYTES - 2'h1)
                ts_r <= T_MODE;
            end
            T_MODE:
            begin
              if (sh_nxt[7:4] == `SPM_XIP_ON_NIB)
              begin
                xip_r     <= 1'b1;
                xip_cmd_r <= ir_r;
              end
              else if (sh_nxt[7:4] == `SPM_XIP_OFF_NIB)
                xip_r <= 1'b0;
              vld_r <= a_vld;
              if (is_rd)
              begin
                rd_r    <= a_vld;
                maddr_r <= addr_r;
                ts_r    <= T_RDATA;
              end
              else
                ts_r <= T_WDATA;
            end
            default:
            begin
              // Commit unless write-disabled, protected or unmapped
              addr_r <= next_addr(addr_r, aug_r);
              if (vld_r && ~wr_block)
              begin
                wr_r    <= 1'b1;
                wdata_r <= sh_nxt;
                maddr_r <= addr_r;
              end
              else
                rej_r <= 1'b1;
            end
          endcase
        end
      end
      else if ((ts_r == T_RDATA) && sck_fall && is_rd)
      begin
        // Byte boundary: fetch the next byte
        if (obits_r == 4'h0)
        begin
          addr_r  <= next_addr(addr_r, aug_r);
          maddr_r <= next_addr(addr_r, aug_r);
          rd_r    <= vld_r;
        end
        osh_r <= obyte << w;
        if (w == 3'h4)
          out_r <= obyte[7:4];
        else if (w == 3'h2)
          out_r <= {2'b00, obyte[7:6]};
        else
          out_r <= {2'b00, obyte[7], 1'b0};
        obits_r <= ((obits_r + {1'b0, w}) == 4'h8) ? 4'h0 : (obits_r + {1'b0, w});
        oe_n_r  <= (w == 3'h4) ? 4'h0 : (w == 3'h2) ? 4'hc : 4'hd;
      end
    end
  end

  // Register write permission, pin and status schemes
  always @(posedge clock or posedge rst)
  begin
    if (rst)
      regw_r <= 1'b0;
    else
      regw_r <= wr_enable & ~(wp_pin_en & ~wp_s);
  end

  assign spi_io_out     = out_r;
  assign spi_io_oe_n    = oe_n_r;
  assign mem_rd         = rd_r;
  assign mem_wr         = wr_r;
  assign mem_aug        = aug_r;
  assign mem_addr       = maddr_r;
  assign mem_wdata      = wdata_r;
  assign pwr_state      = pwr_r;
  assign dev_active     = (pwr_r == P_ACTIVE);
  assign reg_wr_allowed = regw_r;
  assign xip_on         = xip_r;
  assign wr_rejected    = rej_r;

endmodule

/* File: bench/spm_port_props.sv */
// Property checker for the serial memory port
`timescale 1ns/100ps
module spm_port_props
#(
  parameter [15:0] PU_WAIT_CYC   = 16'h61a8,
  parameter [15:0] DEEP_EXIT_CYC = 16'h9c40,
  parameter [15:0] HIB_EXIT_CYC  = 16'hafc8
)
(
  // Clock and reset
  input wire        clock,
  input wire        rst,
  // Pins and configuration
  input wire        spi_cs_n,
  input wire [3:0]  spi_io_oe_n,
  input wire [2:0]  lane_mode,
  input wire        wr_enable,
  input wire        aug_lock,
  input wire [7:0]  aug_sect_prot,
  input wire        mem_busy,
  // Array side and status
  input wire        mem_wr,
  input wire        mem_aug,
  input wire [23:0] mem_addr,
  input wire [2:0]  pwr_state,
  input wire        dev_active,
  input wire        wr_rejected
);
  // Slack for the registered state
  localparam [15:0] EXIT_MAX = ((DEEP_EXIT_CYC > HIB_EXIT_CYC) ? DEEP_EXIT_CYC : HIB_EXIT_CYC) + 16'h0002;
  logic [15:0] exit_cnt_r;
  always @(posedge clock or posedge rst)
    if (rst)
      exit_cnt_r <= 16'h0000;
    else if (pwr_state == 3'h7)
      exit_cnt_r <= exit_cnt_r + 16'h0001;
    else
      exit_cnt_r <= 16'h0000;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_enter;
    $rose(pwr_state == 3'h3 || pwr_state == 3'h5);
  endsequence
  sequence s_asleep;
    pwr_state == 3'h4 || pwr_state == 3'h6;
  endsequence
  a_float_desel: assert property (spi_cs_n [*6] |-> spi_io_oe_n == 4'hf)
    else $error("lanes driven while deselected");
  a_sel_active: assert property ($fell(spi_cs_n) && pwr_state == 3'h1 |-> ##[1:6] dev_active)
    else $error("select did not activate");
  a_busy_hold: assert property ((pwr_state == 3'h2 && mem_busy) [*3] |=> pwr_state == 3'h2)
    else $error("left active while array busy");
  a_entry_time: assert property (s_enter |-> ##[1:300] s_asleep)
    else $error("low-power entry too slow");
  a_exit_time: assert property (exit_cnt_r <= EXIT_MAX)
    else $error("low-power exit too slow");
  a_pu_standby: assert property ($fell(pwr_state == 3'h0) |-> pwr_state == 3'h1)
    else $error("power-up did not end in standby");
  a_wr_gate: assert property (mem_wr |-> wr_enable && !wr_rejected)
    else $error("write passed while disabled");
  a_main_range: assert property (mem_wr && !mem_aug |-> mem_addr[23:21] == 3'h0)
    else $error("main write out of range");
  a_aug_prot: assert property (mem_wr && mem_aug |-> mem_addr[23:8] == 16'h0000 && !aug_lock
                               && !aug_sect_prot[mem_addr[7:5]])
    else $error("protected augmented write");
  a_write_quiet: assert property (mem_wr |-> spi_io_oe_n == 4'hf)
    else $error("lanes driven during write");
  a_lane_oe: assert property (spi_io_oe_n != 4'hf |-> spi_io_oe_n == ((lane_mode == 3'h0 || lane_mode == 3'h7)
                              ? 4'hd : (lane_mode < 3'h4) ? 4'hc : 4'h0))
    else $error("wrong lanes driven");
endmodule

bind spm_port spm_port_props #(
  .PU_WAIT_CYC(PU_WAIT_CYC),
  .DEEP_EXIT_CYC(DEEP_EXIT_CYC),
  .HIB_EXIT_CYC(HIB_EXIT_CYC)
) i_spm_port_props (
  .clock, .rst, .spi_cs_n, .spi_io_oe_n, .lane_mode, .wr_enable, .aug_lock, .aug_sect_prot,
  .mem_busy, .mem_wr, .mem_aug, .mem_addr, .pwr_state, .dev_active, .wr_rejected
);

/* File: bench/spm_host.sv */
// Host serial controller model driving the memory port pins
`timescale 1ns/100ps
module spm_host
(
  // Clock
  input  wire        clock,
  // Host pins
  output logic       cs_n,
  output logic       sck,
  output logic [3:0] io,
  // Resolved lane levels
  input  wire  [3:0] pin
);
  initial
  begin
    cs_n = 1'b1;
    sck  = 1'b0;
    io   = 4'h5;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  // Serial clock idles low between frames
  task automatic open_frame();
    tick(1);
    cs_n <= 1'b0;
    tick(4);
  endtask
  // Unused lanes toggle so stale levels cannot pass
  task automatic put_byte(input logic [7:0] v, input int w, input int nbits);
    logic [7:0] sh;
    sh = v;
    for (int i = 0; i < nbits; i += w)
    begin
      case (w)
        1: io <= {~io[3:1], sh[7]};
        2: io <= {~io[3:2], sh[7:6]};
        default: io <= sh[7:4];
      endcase
      sh = sh << w;
      tick(4);
      sck <= 1'b1;
      tick(4);
      sck <= 1'b0;
    end
  endtask
  // Host keeps lanes moving while reading
  task automatic get_byte(output logic [7:0] v, input int w);
    v = 8'h00;
    for (int i = 0; i < 8; i += w)
    begin
      io <= ~io;
      tick(4);
      sck <= 1'b1;
      tick(4);
      case (w)
        1: v = {v[6:0], pin[1]};
        2: v = {v[5:0], pin[1:0]};
        default: v = {v[3:0], pin};
      endcase
      sck <= 1'b0;
    end
  endtask
  task automatic close_frame();
    tick(4);
    cs_n <= 1'b1;
    io   <= ~io;
    tick(6);
  endtask
endmodule

/* File: bench/testbench.sv */
// Self-checking bench for the serial memory port
`timescale 1ns/100ps
`include "spm_map.vh"
module testbench;
  localparam [15:0] PU_CYC   = 16'h0028;
  localparam [15:0] DEEP_CYC = 16'h0032;
  localparam [15:0] HIB_CYC  = 16'h001e;
  logic        clock;
  logic        rst;
  logic        spi_wp_n;
  logic [2:0]  lane_mode;
  logic        wr_enable;
  logic        wp_pin_en;
  logic        prot_bottom;
  logic [2:0]  prot_blocks;
  logic        aug_lock;
  logic [7:0]  aug_sect_prot;
  logic        mem_busy;
  logic [7:0]  mem_rdata = 8'h00;
  wire         cs_n;
  wire         sck;
  wire  [3:0]  host_io;
  wire  [3:0]  io_out;
  wire  [3:0]  io_oe_n;
  wire  [3:0]  pin;
  wire         mem_wr;
  wire         mem_aug;
  wire  [23:0] mem_addr;
  wire  [7:0]  mem_wdata;
  wire  [2:0]  pwr_state;
  wire         reg_wr_allowed;
  wire         xip_on;
  wire         wr_rejected;
  int          n_mismatch;
  int          cmp_count;
  int          n_wr;
  int          n_rej;
  logic [23:0] wr_addr;
  logic [7:0]  wr_data;
  logic        wr_aug;
  assign pin = (~io_oe_n & io_out) | (io_oe_n & host_io);
  spm_port #(.PU_WAIT_CYC(PU_CYC), .DEEP_EXIT_CYC(DEEP_CYC), .HIB_EXIT_CYC(HIB_CYC)) i_spm_port (
    .clock(clock), .rst(rst), .spi_cs_n(cs_n), .spi_sck(sck), .spi_io_in(pin), .spi_io_out(io_out),
    .spi_io_oe_n(io_oe_n), .spi_wp_n(spi_wp_n), .lane_mode(lane_mode), .wr_enable(wr_enable),
    .wp_pin_en(wp_pin_en), .prot_bottom(prot_bottom), .prot_blocks(prot_blocks), .aug_lock(aug_lock),
    .aug_sect_prot(aug_sect_prot), .mem_rd(), .mem_wr(mem_wr), .mem_aug(mem_aug), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_busy(mem_busy), .pwr_state(pwr_state),
    .dev_active(), .reg_wr_allowed(reg_wr_allowed), .xip_on(xip_on), .wr_rejected(wr_rejected));
  spm_host i_spm_host (.clock(clock), .cs_n(cs_n), .sck(sck), .io(host_io), .pin(pin));
  always #5 clock = ~clock;
  // Array model: data follows the address
  always @(posedge clock)
  begin
    mem_rdata <= mem_addr[7:0] ^ 8'h5a;
    if (mem_wr)
    begin
      n_wr    <= n_wr + 1;
      wr_addr <= mem_addr;
      wr_data <= mem_wdata;
      wr_aug  <= mem_aug;
    end
    if (wr_rejected)
      n_rej <= n_rej + 1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic chk(input logic [32:0] got, input logic [32:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // Lanes per phase: 0 command, 1 address, 2 data
  function automatic int lanes(input logic [2:0] m, input int ph);
    case (ph)
      0: return (m == 3'h3) ? 2 : (m == 3'h6) ? 4 : 1;
      1: return (m == 3'h2 || m == 3'h3) ? 2 : (m == 3'h5 || m == 3'h6) ? 4 : 1;
      default: return (m == 3'h0 || m == 3'h7) ? 1 : (m < 3'h4) ? 2 : 4;
    endcase
  endfunction
  task automatic access(input logic [7:0] op, input logic cmd, input logic [23:0] a, input logic [7:0] mb,
                        input logic [7:0] wd, input logic rd, input int dbits, output logic [7:0] rv);
    rv = 8'h00;
    i_spm_host.open_frame();
    if (cmd)
      i_spm_host.put_byte(op, lanes(lane_mode, 0), 8);
    for (int k = 2; k >= 0; k--)
      i_spm_host.put_byte(a[8*k +: 8], lanes(lane_mode, 1), 8);
    i_spm_host.put_byte(mb, lanes(lane_mode, 1), 8);
    if (rd)
      i_spm_host.get_byte(rv, lanes(lane_mode, 2));
    else
      i_spm_host.put_byte(wd, lanes(lane_mode, 2), dbits);
    i_spm_host.close_frame();
  endtask
  task automatic wr(input logic [7:0] op, input logic [23:0] a, input logic [7:0] d, input logic ok);
    int         w0 = n_wr;
    int         r0 = n_rej;
    logic [7:0] rv;
    access(op, 1'b1, a, 8'hf0, d, 1'b0, 8, rv);
    chk(n_wr != w0, ok, "write issued");
    chk(n_rej != r0, !ok, "write refused");
    if (ok)
      chk({wr_aug, wr_addr, wr_data}, {op == `SPM_OP_WRITE_AUG, a, d}, "write target");
  endtask
  task automatic rd(input logic cmd, input logic [23:0] a, input logic [7:0] mb);
    logic [7:0] rv;
    access(`SPM_OP_READ, cmd, a, mb, 8'h00, 1'b1, 8, rv);
    chk(rv, a[7:0] ^ 8'h5a, "read data");
  endtask
  task automatic t_powerup();
    tick(PU_CYC - 5);
    chk(pwr_state, 3'h0, "power-up wait");
    chk(io_oe_n, 4'hf, "lanes idle");
    tick(10);
    chk(pwr_state, 3'h1, "standby");
  endtask
  task automatic t_lanes();
    for (int m = 0; m < 8; m++)
    begin
      lane_mode <= m[2:0];
      tick(1);
      wr(`SPM_OP_WRITE, {16'h1ff0, m[7:0]}, 8'h3c ^ m[7:0], 1'b1);
      rd(1'b1, {16'h0002, m[7:0]}, 8'hf0);
      tick(4);
      chk(pwr_state, 3'h1, "deselect");
    end
    lane_mode <= 3'h0;
    tick(1);
  endtask
  task automatic t_protect();
    wr_enable <= 1'b0;
    wr(`SPM_OP_WRITE, 24'h000010, 8'h11, 1'b0);
    wr_enable   <= 1'b1;
    prot_blocks <= 3'h6;
    wr(`SPM_OP_WRITE, 24'h100000, 8'h22, 1'b0);
    wr(`SPM_OP_WRITE, 24'h0fffff, 8'h33, 1'b1);
    prot_bottom <= 1'b1;
    wr(`SPM_OP_WRITE, 24'h0fffff, 8'h44, 1'b0);
    wr(`SPM_OP_WRITE, 24'h100000, 8'h55, 1'b1);
    prot_blocks <= 3'h0;
    wr(`SPM_OP_WRITE, 24'h200000, 8'h66, 1'b0);
    wp_pin_en <= 1'b1;
    spi_wp_n  <= 1'b0;
    tick(6);
    chk(reg_wr_allowed, 1'b0, "pin lock");
    wr(`SPM_OP_WRITE, 24'h000020, 8'h67, 1'b1);
    spi_wp_n <= 1'b1;
    tick(6);
    chk(reg_wr_allowed, 1'b1, "pin unlock");
  endtask
  task automatic t_aug();
    aug_sect_prot <= 8'h80;
    wr(`SPM_OP_WRITE_AUG, 24'h0000e0, 8'h77, 1'b0);
    wr(`SPM_OP_WRITE_AUG, 24'h0000df, 8'h88, 1'b1);
    wr(`SPM_OP_WRITE_AUG, 24'h000100, 8'h99, 1'b0);
    aug_lock <= 1'b1;
    wr(`SPM_OP_WRITE_AUG, 24'h000000, 8'haa, 1'b0);
    aug_lock      <= 1'b0;
    aug_sect_prot <= 8'h00;
  endtask
  task automatic t_xip();
    rd(1'b1, 24'h000040, 8'ha0);
    chk(xip_on, 1'b1, "command-free on");
    rd(1'b0, 24'h000041, 8'ha5);
    rd(1'b0, 24'h000042, 8'hf0);
    chk(xip_on, 1'b0, "command-free off");
  endtask
  task automatic t_abort();
    int         w0 = n_wr;
    int         r0 = n_rej;
    logic [7:0] rv;
    access(`SPM_OP_WRITE, 1'b1, 24'h000300, 8'hf0, 8'hc3, 1'b0, 4, rv);
    chk(n_wr != w0 || n_rej != r0, 1'b0, "partial byte");
    wr(`SPM_OP_WRITE, 24'h000301, 8'h3c, 1'b1);
  endtask
  task automatic t_lowpower();
    for (int k = 0; k < 2; k++)
    begin
      mem_busy <= 1'b1;
      i_spm_host.open_frame();
      i_spm_host.put_byte(k ? `SPM_OP_HIBERNATE : `SPM_OP_DEEP_SLEEP, 1, 8);
      i_spm_host.close_frame();
      tick(20);
      chk(pwr_state, 3'h2, "busy hold");
      mem_busy <= 1'b0;
      tick(305);
      chk(pwr_state, k ? 3'h6 : 3'h4, "low-power state");
      i_spm_host.open_frame();
      i_spm_host.close_frame();
      tick(k ? HIB_CYC : DEEP_CYC);
      chk(pwr_state, 3'h1, "wake");
      rd(1'b1, 24'h000055, 8'hf0);
    end
  endtask
  task automatic tally_and_finish();
    if (n_mismatch == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    clock         = 1'b0;
    rst           = 1'b1;
    spi_wp_n      = 1'b1;
    lane_mode     = 3'h0;
    wr_enable     = 1'b1;
    wp_pin_en     = 1'b0;
    prot_bottom   = 1'b0;
    prot_blocks   = 3'h0;
    aug_lock      = 1'b0;
    aug_sect_prot = 8'h00;
    mem_busy      = 1'b0;
    tick(3);
    rst <= 1'b0;
    t_powerup();
    t_lanes();
    t_protect();
    t_aug();
    t_xip();
    t_abort();
    t_lowpower();
    tally_and_finish();
  end
  // Run needs under half of this
  initial
  begin
    tick(40000);
    n_mismatch++;
    tally_and_finish();
  end
endmodule
